// File: rtl/cmd_gear_pkg.sv
// shared constants and types of the command pulse front end
package cmd_gear_pkg;
    // timing: one control cycle equals one smoothing step
    localparam int CLK_PERIOD_NS  = 100;
    localparam int SMOOTH_UNIT_NS = 100000;
    localparam int CTRL_CYCLES    = SMOOTH_UNIT_NS / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_PPR    = 8'h04;
    localparam logic [7:0] OFS_NUM    = 8'h08;
    localparam logic [7:0] OFS_DEN    = 8'h0c;
    localparam logic [7:0] OFS_SMOOTH = 8'h10;
    localparam logic [7:0] OFS_RAW    = 8'h14;
    localparam logic [7:0] OFS_GEARED = 8'h18;
    localparam logic [7:0] OFS_FILT   = 8'h1c;

    // control register fields
    localparam int CTRL_SEL_BIT = 0;
    localparam int CTRL_DIR_BIT = 1;
    localparam int CTRL_MTH_LSB = 2;

    // reset values and setting limits
    localparam logic [3:0]  CTRL_RST   = 4'h0;
    localparam logic [20:0] PPR_RST    = 21'h000000;
    localparam logic [30:0] NUM_RST    = 31'h00000001;
    localparam logic [30:0] DEN_RST    = 31'h00000001;
    localparam logic [13:0] SMOOTH_RST = 14'h0000;
    localparam logic [20:0] PPR_MAX    = 21'h100000;
    localparam logic [30:0] GEAR_MAX   = 31'h40000000;
    localparam logic [13:0] SMOOTH_MAX = 14'h2710;

    typedef enum logic [1:0] {
        CNT_QUAD_A,
        CNT_PULSE_PAIR,
        CNT_QUAD_B,
        CNT_PULSE_SIGN
    } count_method_t;

    // one command input path: pulse pair and sign pair
    typedef struct packed {
        logic pulse_pos;
        logic pulse_neg;
        logic sign_pos;
        logic sign_neg;
    } cmd_pins_t;
endpackage

// File: rtl/cmd_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module cmd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      fill_r;
    logic             push;
    logic             pop;

    // honest full and empty from the fill level
    assign in_ready  = (fill_r != (AW+1)'(DEPTH));
    assign out_valid = (fill_r != '0);
    assign out_data  = mem_r[rd_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage write
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wr_r   <= '0;
            rd_r   <= '0;
            fill_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            end
            if (push && !pop) begin
                fill_r <= fill_r + 1'b1;
            end else if (pop && !push) begin
                fill_r <= fill_r - 1'b1;
            end
        end
    end
endmodule

// File: rtl/cmd_udiv.sv
// iterative unsigned restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module cmd_udiv #(
    parameter int W = 48
) (
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic         start,
    input  wire logic [W-1:0] dividend,
    input  wire logic [W-1:0] divisor,
    output logic              done,
    output logic      [W-1:0] quotient,
    output logic      [W-1:0] remainder
);
    localparam int CW = $clog2(W+1);

    logic [W-1:0]  den_r;
    logic [CW-1:0] left_r;
    logic [W:0]    trial;

    // shift in the next dividend bit
    assign trial = {remainder, quotient[W-1]};

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            den_r     <= '0;
            left_r    <= '0;
            quotient  <= '0;
            remainder <= '0;
            done      <= 1'b0;
        end else begin
            done <= (left_r == CW'(1));
            if (start) begin
                den_r     <= divisor;
                quotient  <= dividend;
                remainder <= '0;
                left_r    <= CW'(W);
            end else if (left_r != '0) begin
                left_r <= left_r - 1'b1;
                if (trial >= {1'b0, den_r}) begin
                    remainder <= W'(trial - {1'b0, den_r});
                    quotient  <= {quotient[W-2:0], 1'b1};
                end else begin
                    remainder <= trial[W-1:0];
                    quotient  <= {quotient[W-2:0], 1'b0};
                end
            end
        end
    end
endmodule

// File: rtl/command_pulse_input_gear.sv
// command pulse input, electronic gear and smoothing filter with apb registers
// How it works
// - three pulse formats: quadrature, pulse pair, sign
// - fast line-receiver path, up to 4 Mpps
// - opto-isolated path, up to 500 kpps
// - opto path also takes line-driver signals
// - one bit selects opto or fast path
// - one bit sets counting direction sense
// - two bits select the counting method
// - count is geared, then sent to position loop
// - pulses per revolution accepted from 0 to 1048576
// - numerator 0 to 1073741824 multiplies the count
// - denominator 1 to 1073741824 divides the count
// - geared command passes a smoothing filter
// - first-order lag, time constant 0..10000 x 0.1 ms
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module command_pulse_input_gear #(
    parameter int          CTRL_PERIOD = cmd_gear_pkg::CTRL_CYCLES,
    parameter logic [30:0] ENC_RES     = 31'h00100000,
    parameter int          FIFO_DEPTH  = 4
) (
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire cmd_gear_pkg::cmd_pins_t fast_pins,
    input  wire cmd_gear_pkg::cmd_pins_t opto_pins,
    output logic      [31:0]             pos_cmd,
    output logic                         pos_cmd_valid
);
    import cmd_gear_pkg::*;

    localparam int TW = $clog2(CTRL_PERIOD);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_GEAR,
        ST_GWAIT,
        ST_FILT,
        ST_FWAIT
    } stage_t;

    // settings
    logic          cmd_input_select_r;
    logic          cmd_direction_sense_r;
    count_method_t cmd_count_method_r;
    logic [20:0]   cmd_pulses_per_rev_r;
    logic [30:0]   gear_numerator_r;
    logic [30:0]   gear_denominator_r;
    logic [13:0]   cmd_smoothing_time_r;

    // input conditioning and decode
    logic [7:0]  sync1_r;
    logic [7:0]  sync2_r;
    logic [7:0]  sync3_r;
    logic [7:0]  clean_r;
    cmd_pins_t   fast_c;
    cmd_pins_t   opto_c;
    logic        ch_a;
    logic        ch_b;
    logic        ch_a_r;
    logic        ch_b_r;
    logic        up;
    logic        dn;
    logic        inc;
    logic        dec;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [31:0] raw_pos_r;
    logic [TW-1:0] tick_r;
    logic        tick;

    // fifo and arithmetic
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [15:0] fifo_out_data;
    stage_t      stage_r;
    logic [47:0] total_r;
    logic [31:0] rem_r;
    logic [31:0] geared_r;
    logic [31:0] filt_r;
    logic [31:0] err_r;
    logic [30:0] eff_num;
    logic [30:0] eff_den;
    logic        div_start;
    logic [47:0] div_a;
    logic [47:0] div_b;
    logic        div_done;
    logic [47:0] div_q;
    logic [47:0] div_r;
    logic        neg;
    logic [31:0] q_s;
    logic [31:0] r_s;
    logic [31:0] step_mag;

    // apb
    logic        acc;
    logic [31:0] rd_val;
    logic        rd_hit;

    // three-stage pin synchroniser, change taken when stages two and three agree
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
            sync3_r <= 8'h00;
            clean_r <= 8'h00;
        end else begin
            sync1_r <= {fast_pins, opto_pins};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            clean_r <= ((sync2_r ~^ sync3_r) & sync3_r) | ((sync2_r ^ sync3_r) & clean_r);
        end
    end

    assign fast_c = clean_r[7:4];
    assign opto_c = clean_r[3:0];

    // path select; both paths decoded alike
    always_comb begin
        if (cmd_input_select_r) begin
            ch_a = fast_c.pulse_pos & ~fast_c.pulse_neg;
            ch_b = fast_c.sign_pos & ~fast_c.sign_neg;
        end else begin
            ch_a = opto_c.pulse_pos & ~opto_c.pulse_neg;
            ch_b = opto_c.sign_pos & ~opto_c.sign_neg;
        end
    end

    always_comb begin
        up = 1'b0;
        dn = 1'b0;
        case (cmd_count_method_r)
            CNT_PULSE_PAIR: begin
                up = ch_a & ~ch_a_r;
                dn = ch_b & ~ch_b_r;
            end
            CNT_PULSE_SIGN: begin
                up = ch_a & ~ch_a_r & ~ch_b;
                dn = ch_a & ~ch_a_r & ch_b;
            end
            default: begin
                // quadrature x4, a double change is dropped as invalid
                if ((ch_a ^ ch_a_r) != (ch_b ^ ch_b_r)) begin
                    up = ch_a ^ ch_b_r;
                    dn = ~(ch_a ^ ch_b_r);
                end
            end
        endcase
    end

    // direction sense swaps up and down
    assign inc = cmd_direction_sense_r ? dn : up;
    assign dec = cmd_direction_sense_r ? up : dn;
    assign cnt_nxt = cnt_r + {{15{dec}}, inc | dec};
    assign tick = (tick_r == TW'(CTRL_PERIOD-1));

    // previous channel levels
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ch_a_r <= 1'b0;
            ch_b_r <= 1'b0;
        end else begin
            ch_a_r <= ch_a;
            ch_b_r <= ch_b;
        end
    end

    // control cycle timer
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tick_r <= '0;
        end else begin
            tick_r <= tick ? '0 : tick_r + 1'b1;
        end
    end

    // per-cycle pulse count, held and still counting while fifo is full
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cnt_r     <= 16'h0000;
            raw_pos_r <= 32'h00000000;
        end else begin
            cnt_r     <= (tick && fifo_in_ready) ? 16'h0000 : cnt_nxt;
            raw_pos_r <= raw_pos_r + {{31{dec}}, inc | dec};
        end
    end

    cmd_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .in_valid  (tick),
        .in_ready  (fifo_in_ready),
        .in_data   (cnt_nxt),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // a nonzero pulses-per-rev overrides the numerator and denominator
    assign eff_num = (cmd_pulses_per_rev_r != '0) ? ENC_RES : gear_numerator_r;
    assign eff_den = (cmd_pulses_per_rev_r != '0) ? {10'h000, cmd_pulses_per_rev_r}
                                                    : gear_denominator_r;
    assign fifo_out_ready = (stage_r == ST_IDLE);

    // shared divider operands
    assign neg = (stage_r == ST_GWAIT) ? total_r[47] : err_r[31];
    always_comb begin
        div_start = 1'b0;
        div_a     = 48'h000000000000;
        div_b     = 48'h000000000001;
        if (stage_r == ST_GEAR) begin
            div_start = 1'b1;
            div_a     = total_r[47] ? 48'(-total_r) : total_r;
            div_b     = {17'h00000, eff_den};
        end else if (stage_r == ST_FILT) begin
            div_start = (cmd_smoothing_time_r != '0);
            div_a     = {16'h0000, err_r[31] ? 32'(-err_r) : err_r};
            div_b     = {34'h000000000, cmd_smoothing_time_r} + 48'h000000000001;
        end
    end

    cmd_udiv #(
        .W (48)
    ) u_div (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .start     (div_start),
        .dividend  (div_a),
        .divisor   (div_b),
        .done      (div_done),
        .quotient  (div_q),
        .remainder (div_r)
    );

    // signed quotient and remainder, truncated toward zero
    assign q_s = neg ? 32'(-div_q[31:0]) : div_q[31:0];
    assign r_s = neg ? 32'(-div_r[31:0]) : div_r[31:0];
    assign step_mag = (div_q[31:0] == 32'h00000000) ? 32'h00000001 : div_q[31:0];

    // gear then filter, once per fifo word
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            stage_r       <= ST_IDLE;
            total_r       <= 48'h000000000000;
            rem_r         <= 32'h00000000;
            geared_r      <= 32'h00000000;
            filt_r        <= 32'h00000000;
            err_r         <= 32'h00000000;
            pos_cmd       <= 32'h00000000;
            pos_cmd_valid <= 1'b0;
        end else begin
            pos_cmd_valid <= 1'b0;
            case (stage_r)
                ST_IDLE: begin
                    if (fifo_out_valid) begin
                        // count times numerator; plus carried remainder
                        total_r <= ($signed({{32{fifo_out_data[15]}}, fifo_out_data})
                                  * $signed({17'h00000, eff_num}))
                                 + {{16{rem_r[31]}}, rem_r};
                        stage_r <= ST_GEAR;
                    end
                end
                ST_GEAR: begin
                    stage_r <= ST_GWAIT;
                end
                ST_GWAIT: begin
                    if (div_done) begin
                        // divide by denominator; keep what is left
                        geared_r <= geared_r + q_s;
                        rem_r    <= r_s;
                        err_r    <= geared_r + q_s - filt_r;
                        stage_r  <= ST_FILT;
                    end
                end
                ST_FILT: begin
                    // zero time constant passes the command straight through
                    if (cmd_smoothing_time_r == '0) begin
                        filt_r        <= geared_r;
                        pos_cmd       <= geared_r;
                        pos_cmd_valid <= 1'b1;
                        stage_r       <= ST_IDLE;
                    end else begin
                        stage_r <= ST_FWAIT;
                    end
                end
                ST_FWAIT: begin
                    if (div_done) begin
                        // first-order lag step, at least one count
                        if (err_r == 32'h00000000) begin
                            pos_cmd <= filt_r;
                        end else if (neg) begin
                            filt_r  <= filt_r - step_mag;
                            pos_cmd <= filt_r - step_mag;
                        end else begin
                            filt_r  <= filt_r + step_mag;
                            pos_cmd <= filt_r + step_mag;
                        end
                        // result handed to the position loop
                        pos_cmd_valid <= 1'b1;
                        stage_r       <= ST_IDLE;
                    end
                end
                default: begin
                    stage_r <= ST_IDLE;
                end
            endcase
        end
    end

    // apb read mux
    assign acc = psel & penable & ~pready;
    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h00000000;
        if (paddr == OFS_CTRL) begin
            rd_val = {28'h0000000, cmd_count_method_r, cmd_direction_sense_r,
                      cmd_input_select_r};
        end else if (paddr == OFS_PPR) begin
            rd_val = {11'h000, cmd_pulses_per_rev_r};
        end else if (paddr == OFS_NUM) begin
            rd_val = {1'b0, gear_numerator_r};
        end else if (paddr == OFS_DEN) begin
            rd_val = {1'b0, gear_denominator_r};
        end else if (paddr == OFS_SMOOTH) begin
            rd_val = {18'h00000, cmd_smoothing_time_r};
        end else if (paddr == OFS_RAW) begin
            rd_val = raw_pos_r;
        end else if (paddr == OFS_GEARED) begin
            rd_val = geared_r;
        end else if (paddr == OFS_FILT) begin
            rd_val = filt_r;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // apb answer one cycle into the access phase
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= acc;
            pslverr <= acc & ~rd_hit;
            prdata  <= (acc && !pwrite) ? rd_val : 32'h00000000;
        end
    end

    // settings written at the completing edge, out-of-range values clamped
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cmd_count_method_r    <= count_method_t'(CTRL_RST[CTRL_MTH_LSB +: 2]);
            cmd_direction_sense_r <= CTRL_RST[CTRL_DIR_BIT];
            cmd_input_select_r    <= CTRL_RST[CTRL_SEL_BIT];
            cmd_pulses_per_rev_r <= PPR_RST;
            gear_numerator_r     <= NUM_RST;
            gear_denominator_r   <= DEN_RST;
            cmd_smoothing_time_r <= SMOOTH_RST;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == OFS_CTRL) begin
                cmd_input_select_r    <= pwdata[CTRL_SEL_BIT];
                cmd_direction_sense_r <= pwdata[CTRL_DIR_BIT];
                cmd_count_method_r    <= count_method_t'(pwdata[CTRL_MTH_LSB +: 2]);
            end else if (paddr == OFS_PPR) begin
                cmd_pulses_per_rev_r <= (pwdata > {11'h000, PPR_MAX}) ? PPR_MAX : pwdata[20:0];
            end else if (paddr == OFS_NUM) begin
                gear_numerator_r <= (pwdata > {1'b0, GEAR_MAX}) ? GEAR_MAX : pwdata[30:0];
            end else if (paddr == OFS_DEN) begin
                // zero raised to one, top clamped
                if (pwdata == 32'h00000000) begin
                    gear_denominator_r <= 31'h00000001;
                end else begin
                    gear_denominator_r <= (pwdata > {1'b0, GEAR_MAX}) ? GEAR_MAX
                                                                      : pwdata[30:0];
                end
            end else if (paddr == OFS_SMOOTH) begin
                cmd_smoothing_time_r <= (pwdata > {18'h00000, SMOOTH_MAX}) ? SMOOTH_MAX
                                                                          : pwdata[13:0];
            end
        end
    end
endmodule

// File: tb/cmd_gear_properties.sv
// port assertions for the command pulse front end
`timescale 1ns/1ps
module cmd_gear_properties #(
    parameter int CTRL_PERIOD = 1000
) (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] pos_cmd,
    input wire logic        pos_cmd_valid
);
    localparam int GAP_MAX = 2 * CTRL_PERIOD + 200;
    int gap_r;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // clocks since the last command update
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            gap_r <= 0;
        end else begin
            gap_r <= pos_cmd_valid ? 0 : gap_r + 1;
        end
    end
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_ready_latency: assert property (psel && penable && !pready |-> ##[0:2] pready)
        else $error("access not answered");
    chk_err_unmapped: assert property (pready && paddr > 8'h1c |-> pslverr && prdata == 32'h0)
        else $error("unmapped access without error");
    chk_err_mapped: assert property (pready && paddr <= 8'h1c && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("error on mapped register");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data outside access");
    chk_valid_single: assert property (pos_cmd_valid |=> !pos_cmd_valid [*8])
        else $error("command updates too close");
    chk_valid_period: assert property (gap_r <= GAP_MAX)
        else $error("command update missing");
    chk_cmd_hold: assert property (!pos_cmd_valid |-> $stable(pos_cmd))
        else $error("command changed without valid");
    chk_reset_quiet: assert property ($fell(reset) |-> pos_cmd == 32'h0 && !pready)
        else $error("outputs busy after reset");
endmodule
bind command_pulse_input_gear cmd_gear_properties #(.CTRL_PERIOD(CTRL_PERIOD)) u_props (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pos_cmd(pos_cmd),
    .pos_cmd_valid(pos_cmd_valid));

// File: tb/host_pulse_gen.sv
// host model driving command pulse trains on either input path
`timescale 1ns/1ps
module host_pulse_gen (
    input  wire logic               clk_sys,
    output cmd_gear_pkg::cmd_pins_t fast_pins,
    output cmd_gear_pkg::cmd_pins_t opto_pins
);
    import cmd_gear_pkg::*;
    logic [1:0] ch_f = 2'b00; // pulse and sign channel levels
    logic [1:0] ch_o = 2'b00;
    assign fast_pins = {ch_f[1], ~ch_f[1], ch_f[0], ~ch_f[0]};
    assign opto_pins = {ch_o[1], ~ch_o[1], ch_o[0], ~ch_o[0]};
    // each level held five clocks, above the sync minimum
    task automatic step(input logic fast, input logic a, input logic b);
        @(posedge clk_sys);
        if (fast) begin
            ch_f <= {a, b};
        end else begin
            ch_o <= {a, b};
        end
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic send(input logic fast, input logic [1:0] m, input int n, input logic up);
        for (int i = 0; i < n; i++) begin
            if (m == 2'd3) begin
                step(fast, 1'b0, ~up);
                step(fast, 1'b1, ~up);
                step(fast, 1'b0, 1'b0);
            end else if (m == 2'd1) begin
                step(fast, up, ~up);
                step(fast, 1'b0, 1'b0);
            end else begin
                step(fast, up, ~up);
                step(fast, 1'b1, 1'b1);
                step(fast, ~up, up);
                step(fast, 1'b0, 1'b0);
            end
        end
    endtask
endmodule

// File: tb/command_pulse_input_gear_test.sv
// self-checking bench: registers, pulse counting, gear, smoothing
`timescale 1ns/1ps
module command_pulse_input_gear_test;
    import cmd_gear_pkg::*;
    localparam int CP = 100;
    localparam logic [31:0] RV [5] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h0};
    localparam logic [7:0]  WA [4] = '{8'h04, 8'h08, 8'h0c, 8'h10};
    localparam logic [31:0] WV [4] = '{32'h1fffff, 32'h7fffffff, 32'h0, 32'h3fff};
    localparam logic [31:0] WE [4] = '{32'h100000, 32'h40000000, 32'h1, 32'h2710};
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, pos_cmd, rd;
    logic        pready, pslverr, pos_cmd_valid, err, sel;
    cmd_pins_t   fast_pins, opto_pins;
    int          n_mismatch = 0;
    int          checks = 0;
    int          cyc = 0;
    int          s, g;
    always #50 clk_sys = ~clk_sys;
    command_pulse_input_gear #(.CTRL_PERIOD(CP)) u_dut (.clk_sys(clk_sys), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fast_pins(fast_pins),
        .opto_pins(opto_pins), .pos_cmd(pos_cmd), .pos_cmd_valid(pos_cmd_valid));
    host_pulse_gen u_host (.clk_sys(clk_sys), .fast_pins(fast_pins), .opto_pins(opto_pins));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // cycle ceiling against hangs
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 5; i++) rchk(8'(4 * i), RV[i]);
        foreach (WA[i]) begin
            apb(1'b1, WA[i], WV[i]);
            rchk(WA[i], WE[i]);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, OFS_RAW, 32'h5);
        rchk(OFS_RAW, 32'h0);
        $display("test registers done");
        apb(1'b1, OFS_PPR, 32'h0);
        apb(1'b1, OFS_SMOOTH, 32'h0);
        apb(1'b1, OFS_NUM, 32'h3);
        apb(1'b1, OFS_DEN, 32'h2);
        s = 0;
        for (int k = 0; k < 8; k++) begin
            sel = k[0] ^ k[1];
            apb(1'b1, OFS_CTRL, {28'h0, k[2:1], k[0], sel});
            u_host.send(sel, k[2:1], 2, ~k[0] | k[1]);
            u_host.send(~sel, k[2:1], 1, 1'b1);
            s += (k[0] & k[1]) ? (k[1] ? -2 : -8) : (k[1] ? 2 : 8);
            repeat (3 * CP) @(posedge clk_sys);
            rchk(OFS_GEARED, 32'(s * 3 / 2));
            chk(pos_cmd, 32'(s * 3 / 2));
        end
        $display("test counting and gear done");
        apb(1'b1, OFS_PPR, 32'h100000);
        apb(1'b1, OFS_DEN, 32'h1);
        apb(1'b1, OFS_SMOOTH, 32'h4);
        apb(1'b1, OFS_CTRL, 32'hc);
        g = s * 3 / 2 + 20;
        u_host.send(1'b0, 2'd3, 20, 1'b1);
        repeat (2 * CP) @(posedge clk_sys);
        rchk(OFS_GEARED, 32'(g));
        chk({31'h0, pos_cmd !== 32'(g)}, 32'h1);
        repeat (60 * CP) @(posedge clk_sys);
        chk(pos_cmd, 32'(g));
        rchk(OFS_FILT, 32'(g));
        $display("test smoothing done");
        give_verdict();
    end
endmodule
